/* src/door_interlock_monitor.v */
// Purpose: supervises contactor feedback, door loop and hall door loop of the lift
// Assumes: all pin inputs asynchronous, active high meaning closed / energised
// Notes:   faults hold until reset; wiring fault has priority over mismatch code
//          three schemes, chosen by the two selects:
//            detect off             - traditional: contactor feedback against door loop
//            detect on, omit off    - separated: contactor, door loop and hall loop
//            detect on, omit on     - no contactor: door loop against hall loop
//          omission without detection is an illegal setting and runs as traditional
//          the hall loop leaves every check but the traditional wiring check while re-levelling or opening early
//          a disagreement must last the full delay without a break to raise a fault
//          the selects are meant to change only while reset is held
`include "door_interlock_map.vh"
module door_interlock_monitor #(
	parameter MISMATCH_CYCLES = `MISMATCH_CYCLES
) (
	input  wire                     CLK_SYS_I,
	input  wire                     RST_N_I,
	input  wire                     CONTACTOR_FEEDBACK_INPUT_I,
	input  wire                     DOOR_LOOP_INPUT_I,
	input  wire                     HALL_DOOR_LOOP_INPUT_I,
	input  wire                     HALL_DOOR_DETECT_SELECT_I,
	input  wire                     CONTACTOR_OMISSION_SELECT_I,
	input  wire                     RELEVEL_OR_ADVANCE_OPEN_I,
	output reg                      RUN_PERMIT_O,
	output reg                      MISMATCH_FAULT_O,
	output reg                      WIRING_FAULT_O,
	output reg [`FAULT_CODE_W-1:0]  FAULT_CODE_O
);
	localparam TIMER_W = 32; // wide enough for the full-speed delay count

	// synchroniser first stages, read only by the second stages
	reg                     contactor_s1_r;
	reg                     door_loop_s1_r;
	reg                     hall_loop_s1_r;
	reg                     detect_s1_r;
	reg                     omit_s1_r;
	reg                     hall_excl_s1_r;

	// synchroniser second stages, the only copies the logic reads
	reg                     contactor_r;
	reg                     door_loop_r;
	reg                     hall_loop_r;
	reg                     detect_r;
	reg                     omit_r;
	reg                     hall_excl_r;

	// next values of the registered outputs
	reg                     run_permit_nxt;
	reg                     mismatch_fault_nxt;
	reg                     wiring_fault_nxt;
	reg [`FAULT_CODE_W-1:0] fault_code_nxt;

	// scheme and supervision signals
	reg                     disagree;
	reg                     doors_closed;
	wire                    contactor_vs_door;
	wire                    door_vs_hall;
	wire                    wiring_bad;
	wire                    expired;
	wire                    traditional;
	wire                    separated;
	wire                    no_contact;
	wire                    hall_used;

	// true when two supervised levels differ
	function pair_differs;
		input a;
		input b;
		begin
			pair_differs = a ^ b;
		end
	endfunction

	// a loop counts as closed when its level is high or it is excluded
	function loop_ok;
		input level;
		input excluded;
		begin
			loop_ok = level | excluded;
		end
	endfunction

	// contactor feedback synchroniser
	always @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			contactor_s1_r <= 1'b0;
			contactor_r    <= 1'b0;
		end else begin
			contactor_s1_r <= CONTACTOR_FEEDBACK_INPUT_I;
			contactor_r    <= contactor_s1_r;
		end
	end

	// door loop synchroniser
	always @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			door_loop_s1_r <= 1'b0;
			door_loop_r    <= 1'b0;
		end else begin
			door_loop_s1_r <= DOOR_LOOP_INPUT_I;
			door_loop_r    <= door_loop_s1_r;
		end
	end

	// hall door loop synchroniser
	always @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			hall_loop_s1_r <= 1'b0;
			hall_loop_r    <= 1'b0;
		end else begin
			hall_loop_s1_r <= HALL_DOOR_LOOP_INPUT_I;
			hall_loop_r    <= hall_loop_s1_r;
		end
	end

	// hall detection select synchroniser
	always @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			detect_s1_r <= 1'b0;
			detect_r    <= 1'b0;
		end else begin
			detect_s1_r <= HALL_DOOR_DETECT_SELECT_I;
			detect_r    <= detect_s1_r;
		end
	end

	// contactor omission select synchroniser
	always @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			omit_s1_r <= 1'b0;
			omit_r    <= 1'b0;
		end else begin
			omit_s1_r <= CONTACTOR_OMISSION_SELECT_I;
			omit_r    <= omit_s1_r;
		end
	end

	// re-level or early opening synchroniser
	always @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			hall_excl_s1_r <= 1'b0;
			hall_excl_r    <= 1'b0;
		end else begin
			hall_excl_s1_r <= RELEVEL_OR_ADVANCE_OPEN_I;
			hall_excl_r    <= hall_excl_s1_r;
		end
	end

	// scheme decode; omission without detection runs as traditional
	assign traditional = !detect_r;                 // RULE2 RULE9
	assign separated   = detect_r && !omit_r;
	assign no_contact  = detect_r && omit_r;        // RULE6
	assign hall_used   = detect_r && !hall_excl_r;  // RULE8

	// pairwise comparisons of the supervised levels
	assign contactor_vs_door = pair_differs(contactor_r, door_loop_r);
	assign door_vs_hall      = pair_differs(door_loop_r, hall_loop_r);

	// disagreement of the supervised inputs
	always @* begin
		disagree = 1'b0;
		if (separated) begin
			if (hall_used)
				disagree = contactor_vs_door || door_vs_hall; // RULE4
			else
				disagree = contactor_vs_door;
		end else if (no_contact) begin
			if (hall_used)
				disagree = door_vs_hall; // RULE5 RULE6
		end else begin
			disagree = contactor_vs_door; // RULE2
		end
	end

	// wiring fault: unexpected input seen active in a scheme that leaves it unused
	assign wiring_bad = (traditional && hall_loop_r) || // RULE3
		(no_contact && contactor_r);                    // RULE7

	// run permit condition: hall and car door loops closed
	always @* begin
		if (traditional)
			doors_closed = door_loop_r && contactor_r;
		else if (separated)
			doors_closed = door_loop_r && contactor_r && loop_ok(hall_loop_r, hall_excl_r);
		else
			doors_closed = door_loop_r && loop_ok(hall_loop_r, hall_excl_r);
	end

	// delay that a disagreement must outlast
	mismatch_timer #(
		.CNT_W (TIMER_W),
		.LIMIT (MISMATCH_CYCLES)
	) u_timer (
		.clk_i      (CLK_SYS_I),
		.rst_n_i    (RST_N_I),
		.disagree_i (disagree),
		.expired_o  (expired)
	);

	// next output values; faults are sticky until reset
	always @* begin
		mismatch_fault_nxt = MISMATCH_FAULT_O || expired; // RULE4 RULE5
		wiring_fault_nxt   = WIRING_FAULT_O || wiring_bad; // RULE3 RULE7
		fault_code_nxt     = FAULT_CODE_O;
		if (wiring_fault_nxt)
			fault_code_nxt = `FAULT_CODE_WIRING;
		else if (mismatch_fault_nxt)
			fault_code_nxt = `FAULT_CODE_MISMATCH;
		run_permit_nxt = doors_closed && !disagree && !wiring_fault_nxt
			&& !mismatch_fault_nxt; // RULE1
	end

	// registered outputs
	always @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			RUN_PERMIT_O     <= 1'b0;
			MISMATCH_FAULT_O <= 1'b0;
			WIRING_FAULT_O   <= 1'b0;
			FAULT_CODE_O     <= `FAULT_CODE_NONE;
		end else begin
			RUN_PERMIT_O     <= run_permit_nxt;
			MISMATCH_FAULT_O <= mismatch_fault_nxt;
			WIRING_FAULT_O   <= wiring_fault_nxt;
			FAULT_CODE_O     <= fault_code_nxt;
		end
	end
endmodule // door_interlock_monitor

/* src/door_interlock_map.vh */
// Purpose: constants for the door interlock monitor
// Assumes: 50 MHz system clock, 20 ns period
// Notes:   fault codes are the displayed error numbers
// Function
// (RULE1) Car may run only while hall and car door loops both show closed.
// (RULE2) Both selects off: supervise contactor feedback and door loop, combined check.
// (RULE3) Traditional scheme: active hall door input raises wiring fault code 62.
// (RULE4) Detect on, contactor kept: any two of three inputs differ 3 s, fault 26.
// (RULE5) Detect and omission on: door loop and hall loop differ 3 s, fault 26.
// (RULE6) Without contactor, its feedback is ignored; door and hall loops supervised.
// (RULE7) Without contactor, active contactor feedback raises wiring fault code 62.
// (RULE8) Re-levelling or advance door opening excludes hall door input from checks; the code still applies the traditional wiring check to it.
// (RULE9) Configuring party enables omission only with hall detection also enabled.
// (RULE10) Mismatch delay restarts when inputs agree; fault needs unbroken full delay.
`ifndef DOOR_INTERLOCK_MAP_VH
`define DOOR_INTERLOCK_MAP_VH
`define MISMATCH_TIME_MS   3000
`define CLK_PERIOD_NS      20
`define MISMATCH_CYCLES    (`MISMATCH_TIME_MS * (1000000 / `CLK_PERIOD_NS))
`define FAULT_CODE_W       7
`define FAULT_CODE_NONE    7'h00
`define FAULT_CODE_WIRING  7'h3E
`define FAULT_CODE_MISMATCH 7'h1A
`endif

/* src/mismatch_timer.v */
// Purpose: counts an uninterrupted disagreement and flags it when the delay expires
// Assumes: inputs synchronous to clk_i
// Notes:   the count restarts whenever disagree_i drops
module mismatch_timer #(
	parameter CNT_W   = 28,
	parameter LIMIT   = 150000000
) (
	input  wire clk_i,
	input  wire rst_n_i,
	input  wire disagree_i,
	output reg  expired_o
);
	localparam [CNT_W-1:0] LIMIT_M1 = LIMIT - 1;
	reg [CNT_W-1:0] cnt_r;

	// count while disagreeing, restart on agreement
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_r     <= {CNT_W{1'b0}};
			expired_o <= 1'b0;
		end else if (!disagree_i) begin
			cnt_r     <= {CNT_W{1'b0}}; // RULE10
			expired_o <= 1'b0;
		end else if (cnt_r >= LIMIT_M1) begin
			expired_o <= 1'b1;
		end else begin
			cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end
endmodule // mismatch_timer

/* dv/door_contacts.sv */
// Purpose: door lock contacts and interlock contactor; Assumes: bench sets levels; Notes: none
module door_contacts (
	input  wire  clk_i, cl_i, br_i, om_i, tr_i, mw_i,
	output logic cf_o, dl_o, hl_o
);
	timeunit 1ns; timeprecision 1ns;
	logic cf_r = 1'b0;
	// loop closed by contacts or a bridge; contactor pulls in a cycle late; miswire feeds spare pin
	assign dl_o = cl_i | br_i;
	assign hl_o = tr_i ? mw_i : cl_i;
	assign cf_o = om_i ? mw_i : cf_r;
	always @(posedge clk_i) cf_r <= dl_o;
endmodule // door_contacts

/* dv/door_interlock_monitor_chk.sv */
// Purpose: port checker; Assumes: selects move only in reset; Notes: n_r counts disagreement
module door_chk #(parameter MISMATCH_CYCLES = 20) (
	input wire CLK_SYS_I, RST_N_I, CONTACTOR_FEEDBACK_INPUT_I, DOOR_LOOP_INPUT_I,
	input wire HALL_DOOR_LOOP_INPUT_I, HALL_DOOR_DETECT_SELECT_I, CONTACTOR_OMISSION_SELECT_I,
	input wire RELEVEL_OR_ADVANCE_OPEN_I, RUN_PERMIT_O, MISMATCH_FAULT_O, WIRING_FAULT_O,
	input wire [6:0] FAULT_CODE_O
);
	wire h = HALL_DOOR_DETECT_SELECT_I, d = DOOR_LOOP_INPUT_I, c = CONTACTOR_FEEDBACK_INPUT_I;
	wire o = h & CONTACTOR_OMISSION_SELECT_I;
	wire x = h ? (d != HALL_DOOR_LOOP_INPUT_I & !RELEVEL_OR_ADVANCE_OPEN_I | !o & c != d) : c != d;
	int n_r;
	// length of the running disagreement
	always @(posedge CLK_SYS_I or negedge RST_N_I) n_r <= !RST_N_I ? 0 : x ? n_r + 1 : 0;
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (!RST_N_I);
	a_run_closed: assert property (RUN_PERMIT_O |-> $past(d, 3)) else $error("run");
	a_wire_trad: assert property (!h && $past(RST_N_I, 3) && $past(HALL_DOOR_LOOP_INPUT_I, 3)
		|-> WIRING_FAULT_O) else $error("wiring");
	a_wire_omit: assert property (o && $past(RST_N_I, 3) && $past(c, 3) |-> WIRING_FAULT_O)
		else $error("wiring");
	a_wire_code: assert property (WIRING_FAULT_O |-> FAULT_CODE_O == 7'h3E) else $error("code");
	a_mism_code: assert property (MISMATCH_FAULT_O && !WIRING_FAULT_O |-> FAULT_CODE_O == 7'h1A)
		else $error("code");
	a_wire_held: assert property (WIRING_FAULT_O |=> WIRING_FAULT_O) else $error("held");
	a_mism_early: assert property ($rose(MISMATCH_FAULT_O) |-> n_r >= MISMATCH_CYCLES)
		else $error("early");
	a_mism_late: assert property (n_r == MISMATCH_CYCLES + 8 |-> MISMATCH_FAULT_O)
		else $error("late");
	c_wire: cover property (WIRING_FAULT_O);
	c_mism: cover property (MISMATCH_FAULT_O);
	c_run: cover property (RUN_PERMIT_O);
endmodule // door_chk
bind door_interlock_monitor door_chk #(.MISMATCH_CYCLES(MISMATCH_CYCLES)) chk_u (.*);

/* dv/tb_top.sv */
// Purpose: bench of the door monitor; Assumes: delay cut to M cycles; Notes: one task a scheme
module tb_top;
	timeunit 1ns; timeprecision 1ns;
	localparam int M = 20;
	logic clk = 0, rst_n = 0, cl = 0, br = 0, mw = 0, hd = 0, om = 0, rl = 0, cf, dl, hl, rp, mf, wf;
	logic [6:0] fc;
	int err_count = 0, n_compared = 0;
`define CHK(n, e, a) begin @(negedge clk); n_compared++; if ((a) !== (e)) begin err_count++; \
	$display("[ERR] %s exp %h got %h", n, e, a); end @(posedge clk); end
	// system clock
	initial forever #10 clk = ~clk;
	door_contacts part_u (.clk_i(clk), .cl_i(cl), .br_i(br), .om_i(om), .tr_i(!hd), .mw_i(mw),
		.cf_o(cf), .dl_o(dl), .hl_o(hl));
	door_interlock_monitor #(.MISMATCH_CYCLES(M)) dut_u (.CLK_SYS_I(clk), .RST_N_I(rst_n),
		.CONTACTOR_FEEDBACK_INPUT_I(cf), .DOOR_LOOP_INPUT_I(dl), .HALL_DOOR_LOOP_INPUT_I(hl),
		.HALL_DOOR_DETECT_SELECT_I(hd), .CONTACTOR_OMISSION_SELECT_I(om),
		.RELEVEL_OR_ADVANCE_OPEN_I(rl), .RUN_PERMIT_O(rp), .MISMATCH_FAULT_O(mf),
		.WIRING_FAULT_O(wf), .FAULT_CODE_O(fc));
	task cyc(int n); repeat (n) @(posedge clk); endtask
	// reset into a new scheme with all contacts open
	task cfg(logic h, logic o); @(posedge clk); {rst_n, hd, om, cl, br, mw, rl} <= {1'b0, h, o, 4'h0};
		cyc(10); rst_n <= 1; cyc(2); endtask
	task t_trad; cfg(0, 0); cl <= 1; cyc(6); `CHK("rp", 1'b1, rp)
		cl <= 0; cyc(6); `CHK("rp", 1'b0, rp)
		mw <= 1; cyc(6); `CHK("fc", 7'h3E, fc)
		$display("trad done"); endtask
	task t_sep; cfg(1, 0); cl <= 1; cyc(6); `CHK("rp", 1'b1, rp)
		repeat (2) begin {cl, br} <= 2'h1; cyc(M - 6); {cl, br} <= 2'h2; cyc(4); end
		`CHK("mf", 1'b0, mf)
		{rl, cl, br} <= 3'h5; cyc(M + 6); `CHK("mf", 1'b0, mf)
		rl <= 0; cyc(6); `CHK("rp", 1'b0, rp)
		cyc(M); `CHK("fc", 7'h1A, fc)
		$display("sep done"); endtask
	task t_omit; cfg(1, 1);
		cl <= 1; cyc(6); `CHK("rp", 1'b1, rp)
		{cl, br} <= 2'h1; cyc(M + 6); `CHK("mf", 1'b1, mf)
		mw <= 1; cyc(6); `CHK("wf", 1'b1, wf)
		$display("omit done"); endtask
	task complete_run; $display("compared %0d errors %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish; endtask
	// main sequence and watchdog
	initial begin t_trad; t_sep; t_omit; complete_run; end
	initial begin #20us; err_count++; complete_run; end
endmodule // tb_top
